// file: watchdog_pkg.sv
`default_nettype none
package watchdog_pkg;

	// Register offsets, byte addresses from the instance base
	localparam logic [7:0] OFS_RELOAD = 8'h00;
	localparam logic [7:0] OFS_CONTROL = 8'h04;
	localparam logic [7:0] OFS_RESTART = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h0c;

	// Control field positions
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_TEST_BIT = 1;
	localparam int CTL_HIB_BIT = 2;
	localparam int CTL_WEEK_BIT = 3;
	localparam int CTL_DEBUG_BIT = 4;
	localparam int CTL_W = 5;

	// Values after system reset
	localparam logic [15:0] RELOAD_RST = 16'hffff;
	localparam logic [15:0] COUNT_RST = 16'hffff;
	localparam logic [4:0] CONTROL_RST = 5'h00;

	// Timing: host clock and the slow functional rate, each in Hz
	localparam int HOST_CLK_HZ = 10_000_000;
	localparam int SLOW_CLK_HZ = 32_768;
	// Longest whole number of host cycles per slow period (rounded down)
	localparam int SLOW_DIV_CYCLES = HOST_CLK_HZ / SLOW_CLK_HZ;
	// Slow periods per count step
	localparam int STEP_SLOW_TICKS = 33;

	// Operating states of the counter
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_RUN = 2'b01,
		ST_HOLD = 2'b10,
		ST_FIRED = 2'b11
	} state_t;

	// One register access from the controller, taken in a single cycle
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} bus_req_t;

	// Internal activity signals that may freeze the count
	typedef struct packed {
		logic debug;
		logic week;
		logic hib;
	} stall_t;

endpackage
`default_nettype wire

// file: watchdog_timer.sv
// What this block does
// - When enabled, missing a reload before the interval ends raises a watchdog event.
// - Register reads and writes run on the host clock and finish at once.
// - Counter and functional logic advance on the 32 kHz rate.
// - System reset returns all registers and logic to defaults except the status flag.
// - Bits kept across a watchdog event are cleared only by the second reset.
// - Expiry drives an event output that resets the controller, held until system reset.
// - The activation sequence starts the down-counter.
// - Clearing enable stops counting and gates the functional rate for low power.
// - Underflow before reload raises the event and sets the status flag.
// - Load write, kick write, or watchdog event reloads the counter.
// - Interval is load value down to zero; each step is 33 slow periods.
// - An enabled stall input halts counting and enters low power.
// - After a stall the count resumes from the value it held.
// - Load at 00h, control at 04h, kick at 08h, count at 0Ch.
// - Load is 16-bit read/write at bits 15:0, default FFFFh; writing reloads.
// - Kick reads zero; writes reload while enabled and are ignored when disabled.
// - Control bits 4, 3, 2 enable debug, week and hibernation stalls, default zero.
// - Control bit 0 is the enable, reset to zero.
// - Count register reads the current 16-bit count, reset FFFFh.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer #(
	parameter int COUNT_W = 16,
	parameter int DIV_CYCLES = watchdog_pkg::SLOW_DIV_CYCLES,
	parameter int STEP_TICKS = watchdog_pkg::STEP_SLOW_TICKS
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic event_surviving_reset_n,
	input wire watchdog_pkg::bus_req_t bus_req,
	input wire watchdog_pkg::stall_t stall_in,
	output logic [31:0] rdata,
	output logic watchdog_event,
	output logic event_flag,
	output logic low_power
);

	// Address match, shared by every decode below
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction

	logic [COUNT_W-1:0] reload_r;
	logic [COUNT_W-1:0] reload_nxt;
	logic [COUNT_W-1:0] count_r;
	logic [watchdog_pkg::CTL_W-1:0] control_r;
	watchdog_pkg::state_t state_r;
	watchdog_pkg::state_t state_nxt;
	logic [$clog2(DIV_CYCLES)-1:0] div_r;
	logic [$clog2(STEP_TICKS)-1:0] step_r;
	logic [31:0] rdata_r;
	logic event_r;
	logic flag_r;
	logic low_power_r;
	logic wr_reload;
	logic wr_control;
	logic wr_restart;
	logic enabled;
	logic stalled;
	logic tick;
	logic step_due;
	logic underflow;
	logic reload_req;

	// Register decode, all on the host clock so no access waits on the slow rate
	always_comb begin
		wr_reload = 1'b0;
		wr_control = 1'b0;
		wr_restart = 1'b0;
		if (bus_req.wr && hit(bus_req.addr, watchdog_pkg::OFS_RELOAD)) begin
			wr_reload = 1'b1;
		end else if (bus_req.wr && hit(bus_req.addr, watchdog_pkg::OFS_CONTROL)) begin
			wr_control = 1'b1;
		end else if (bus_req.wr && hit(bus_req.addr, watchdog_pkg::OFS_RESTART)) begin
			wr_restart = 1'b1;
		end
	end

	assign enabled = control_r[watchdog_pkg::CTL_ENABLE_BIT];

	// A stall source only counts when its enable bit is set
	assign stalled = (control_r[watchdog_pkg::CTL_DEBUG_BIT] && stall_in.debug)
		|| (control_r[watchdog_pkg::CTL_WEEK_BIT] && stall_in.week)
		|| (control_r[watchdog_pkg::CTL_HIB_BIT] && stall_in.hib);

	// Slow-rate enable and step boundary, only while running
	assign tick = (state_r == watchdog_pkg::ST_RUN) && (div_r == ($bits(div_r))'(DIV_CYCLES - 1));
	assign step_due = tick && (step_r == ($bits(step_r))'(STEP_TICKS - 1));
	assign underflow = step_due && (count_r == '0);

	// Kick only acts while the enable bit is set; a fired block ignores all reloads
	assign reload_req = (wr_reload || (wr_restart && enabled) || underflow)
		&& (state_r != watchdog_pkg::ST_FIRED);

	assign reload_nxt = wr_reload ? bus_req.wdata[COUNT_W-1:0] : reload_r;

	// Counter state machine
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			watchdog_pkg::ST_OFF: begin
				if (enabled) begin
					state_nxt = stalled ? watchdog_pkg::ST_HOLD : watchdog_pkg::ST_RUN;
				end
			end
			watchdog_pkg::ST_RUN: begin
				if (underflow) begin
					state_nxt = watchdog_pkg::ST_FIRED;
				end else if (!enabled) begin
					state_nxt = watchdog_pkg::ST_OFF;
				end else if (stalled) begin
					state_nxt = watchdog_pkg::ST_HOLD;
				end
			end
			watchdog_pkg::ST_HOLD: begin
				if (!enabled) begin
					state_nxt = watchdog_pkg::ST_OFF;
				end else if (!stalled) begin
					state_nxt = watchdog_pkg::ST_RUN;
				end
			end
			watchdog_pkg::ST_FIRED: begin
				state_nxt = watchdog_pkg::ST_FIRED; // Left only by system reset
			end
			default: begin
				state_nxt = watchdog_pkg::ST_OFF;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r <= watchdog_pkg::ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Load register, written directly from the bus
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			reload_r <= COUNT_W'(watchdog_pkg::RELOAD_RST);
		end else begin
			reload_r <= reload_nxt;
		end
	end

	// Control register; bit 1 is read-only zero, the rest are stored
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			control_r <= watchdog_pkg::CONTROL_RST;
		end else if (wr_control) begin
			control_r <= bus_req.wdata[watchdog_pkg::CTL_W-1:0] & 5'h1d;
		end
	end

	// Slow-rate divider: held in a stall, cleared on reload, gated when off
	// Holding rather than clearing in a stall keeps the partial period, so resume is exact
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			div_r <= '0;
		end else if (reload_req || state_r == watchdog_pkg::ST_OFF) begin
			div_r <= '0;
		end else if (state_r == watchdog_pkg::ST_RUN) begin
			div_r <= tick ? '0 : div_r + 1'b1;
		end
	end

	// Step prescaler: 33 slow periods per count
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			step_r <= '0;
		end else if (reload_req || state_r == watchdog_pkg::ST_OFF) begin
			step_r <= '0;
		end else if (tick) begin
			step_r <= step_due ? '0 : step_r + 1'b1;
		end
	end

	// Down-counter: reload wins over a step in the same cycle
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			count_r <= COUNT_W'(watchdog_pkg::COUNT_RST);
		end else if (reload_req) begin
			count_r <= reload_nxt;
		end else if (step_due) begin
			count_r <= count_r - 1'b1;
		end
	end

	// Event output holds from expiry until the system reset it triggers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			event_r <= 1'b0;
		end else if (underflow) begin
			event_r <= 1'b1;
		end
	end

	// Status flag survives the event; only the second reset clears it
	always_ff @(posedge clock or negedge event_surviving_reset_n) begin
		if (!event_surviving_reset_n) begin
			flag_r <= 1'b0;
		end else if (underflow) begin
			flag_r <= 1'b1;
		end
	end

	// Low power while disabled or stalled, unless the block has fired
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			low_power_r <= 1'b1;
		end else begin
			low_power_r <= (state_nxt == watchdog_pkg::ST_OFF) || (state_nxt == watchdog_pkg::ST_HOLD);
		end
	end

	// Read data registered one cycle after the request; unmapped and kick read zero
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= 32'h0000_0000;
		end else if (bus_req.rd) begin
			if (hit(bus_req.addr, watchdog_pkg::OFS_RELOAD)) begin
				rdata_r <= 32'(reload_r);
			end else if (hit(bus_req.addr, watchdog_pkg::OFS_CONTROL)) begin
				rdata_r <= 32'(control_r);
			end else if (hit(bus_req.addr, watchdog_pkg::OFS_COUNT)) begin
				rdata_r <= 32'(count_r);
			end else begin
				rdata_r <= 32'h0000_0000;
			end
		end else begin
			rdata_r <= 32'h0000_0000;
		end
	end

	assign rdata = rdata_r;
	assign watchdog_event = event_r;
	assign event_flag = flag_r;
	assign low_power = low_power_r;

endmodule
`default_nettype wire

// file: watchdog_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_monitor (
	input wire logic clock,
	input wire logic nrst,
	input wire logic event_surviving_reset_n,
	input wire watchdog_pkg::bus_req_t bus_req,
	input wire watchdog_pkg::stall_t stall_in,
	input wire logic [31:0] rdata,
	input wire logic watchdog_event,
	input wire logic event_flag,
	input wire logic low_power
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Bus answers: one cycle after the read strobe, zero otherwise
	rdata_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 32'h0) else $error("rdata not idle");
	kick_reads_zero_a: assert property (bus_req.rd && bus_req.addr == watchdog_pkg::OFS_RESTART |=> rdata == 32'h0)
		else $error("kick read not zero");
	ctl_spare_zero_a: assert property (bus_req.rd && bus_req.addr == watchdog_pkg::OFS_CONTROL |=>
		rdata[31:5] == 27'h0 && !rdata[1]) else $error("control spare bits set");
	load_readback_a: assert property (bus_req.wr && bus_req.addr == watchdog_pkg::OFS_RELOAD ##1
		bus_req.rd && !bus_req.wr && bus_req.addr == watchdog_pkg::OFS_RELOAD |=>
		rdata == {16'h0, $past(bus_req.wdata[15:0], 2)}) else $error("load readback wrong");
	load_reloads_a: assert property (bus_req.wr && bus_req.addr == watchdog_pkg::OFS_RELOAD && !watchdog_event ##1
		bus_req.rd && !bus_req.wr && bus_req.addr == watchdog_pkg::OFS_COUNT |=>
		rdata == {16'h0, $past(bus_req.wdata[15:0], 2)}) else $error("load did not reload count");
	// Enable and disable act on the power state at the second edge
	enable_runs_a: assert property (bus_req.wr && bus_req.addr == watchdog_pkg::OFS_CONTROL && bus_req.wdata[0]
		&& bus_req.wdata[4:2] == 3'h0 && !watchdog_event |=> ##1 !low_power) else $error("enable did not run");
	// The state follows the stored enable one edge later, so the power flag moves on the second edge
	disable_sleeps_a: assert property (bus_req.wr && bus_req.addr == watchdog_pkg::OFS_CONTROL && !bus_req.wdata[0]
		&& !watchdog_event |=> ##1 low_power) else $error("disable did not sleep");
	// The event only comes from a running counter, and stays with its flag
	event_from_run_a: assert property ($rose(watchdog_event) |-> !$past(low_power) && event_flag)
		else $error("event without running counter");
	event_held_a: assert property (watchdog_event |=> watchdog_event[*3]) else $error("event dropped");
	expiry_c: cover property ($rose(watchdog_event));
	stall_c: cover property (stall_in.hib && low_power);
	kick_c: cover property (bus_req.wr && bus_req.addr == watchdog_pkg::OFS_RESTART);
endmodule
bind watchdog_timer watchdog_timer_monitor i_mon (.clock(clock), .nrst(nrst),
	.event_surviving_reset_n(event_surviving_reset_n), .bus_req(bus_req), .stall_in(stall_in), .rdata(rdata),
	.watchdog_event(watchdog_event), .event_flag(event_flag), .low_power(low_power));
`default_nettype wire

// file: watchdog_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_tb_top;
	// Short divider and prescaler keep expiry within a few dozen cycles
	localparam int STEP = 6;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic keep_n = 1'b0;
	watchdog_pkg::bus_req_t req = '0;
	watchdog_pkg::stall_t stall = '0;
	logic [31:0] rdata;
	logic ev;
	logic flag;
	logic lp;
	logic [31:0] q;
	logic [31:0] q2;
	int n_errors = 0;
	int cmp_count = 0;
	int t;
	watchdog_timer #(.DIV_CYCLES(3), .STEP_TICKS(2)) i_dut (.clock(clock), .nrst(nrst),
		.event_surviving_reset_n(keep_n), .bus_req(req), .stall_in(stall), .rdata(rdata),
		.watchdog_event(ev), .event_flag(flag), .low_power(lp));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One access per call; read data is taken the cycle after the strobe
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(negedge clock);
		req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clock);
		q = rdata;
		req = '0;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic t_defaults();
		logic [7:0] ofs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
		logic [31:0] dflt [5] = '{32'hffff, 32'h0, 32'h0, 32'hffff, 32'h0};
		chk("low_power", 32'h1, {31'h0, lp});
		foreach (ofs[i]) begin
			acc(1'b0, ofs[i], 32'h0);
			chk("default", dflt[i], q);
		end
		acc(1'b1, 8'h04, 32'hffff_fffe);
		acc(1'b0, 8'h04, 32'h0);
		chk("control", 32'h1c, q);
		$display("defaults done");
	endtask
	// Disable freezes the count, and a kick while disabled does nothing
	task automatic t_freeze();
		acc(1'b1, 8'h00, 32'h14);
		acc(1'b1, 8'h04, 32'h1);
		// Power flag leaves its idle level at the same edge the state enters run
		@(negedge clock);
		chk("running", 32'h0, {31'h0, lp});
		repeat (3 * STEP) @(negedge clock);
		acc(1'b1, 8'h04, 32'h0);
		acc(1'b0, 8'h0c, 32'h0);
		chk("counted", 32'h1, {31'h0, q < 32'h14});
		q2 = q;
		acc(1'b1, 8'h08, 32'h0);
		repeat (2 * STEP) @(negedge clock);
		acc(1'b0, 8'h0c, 32'h0);
		chk("frozen", q2, q);
		$display("freeze done");
	endtask
	// Each stall source in turn halts counting, then counting resumes
	task automatic t_stall();
		for (int k = 0; k < 3; k++) begin
			stall = watchdog_pkg::stall_t'(3'b001 << k);
			acc(1'b1, 8'h04, 32'h1 | (32'h4 << k));
			acc(1'b0, 8'h0c, 32'h0);
			q2 = q;
			repeat (3 * STEP) @(negedge clock);
			chk("stalled", 32'h1, {31'h0, lp});
			acc(1'b0, 8'h0c, 32'h0);
			chk("held", q2, q);
			stall = '0;
			repeat (2 * STEP) @(negedge clock);
			acc(1'b0, 8'h0c, 32'h0);
			chk("resumed", 32'h1, {31'h0, q < q2 && q2 - q <= 32'h3});
			acc(1'b1, 8'h04, 32'h0);
		end
		$display("stall done");
	endtask
	// Regular kicks keep it alive; once they stop the event fires
	task automatic t_expire();
		acc(1'b1, 8'h00, 32'h3);
		acc(1'b1, 8'h04, 32'h1);
		repeat (10) begin
			repeat (2 * STEP) @(negedge clock);
			acc(1'b1, 8'h08, 32'h0);
		end
		chk("no event", 32'h0, {31'h0, ev});
		t = 0;
		while (ev !== 1'b1 && t < 100) begin
			@(negedge clock);
			t++;
		end
		if (t >= 100) begin
			chk("timeout", 32'h1, 32'h0);
			tally_and_finish();
		end
		chk("interval", 32'h1, {31'h0, t >= 4 * STEP - 2 && t <= 4 * STEP + 2});
		chk("flag", 32'h1, {31'h0, flag});
		repeat (5) @(negedge clock);
		chk("held", 32'h1, {31'h0, ev});
		nrst = 1'b0;
		repeat (2) @(negedge clock);
		nrst = 1'b1;
		chk("cleared", 32'h0, {31'h0, ev});
		chk("kept", 32'h1, {31'h0, flag});
		keep_n = 1'b0;
		@(negedge clock);
		keep_n = 1'b1;
		chk("flag reset", 32'h0, {31'h0, flag});
		$display("expire done");
	endtask
	initial begin
		forever #50 clock = ~clock;
	end
	initial begin
		repeat (16) @(negedge clock);
		nrst = 1'b1;
		keep_n = 1'b1;
		t_defaults();
		t_freeze();
		t_stall();
		t_expire();
		tally_and_finish();
	end
endmodule
`default_nettype wire
